// ===== include/iec_pkg.sv
// Shared constants and carrier types for the information element codec
package iec_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses; buffer pages are address bits 7:5)
	// ----------------------------------------------------------------
	localparam logic [7:0] A_CTRL   = 8'h00;
	localparam logic [7:0] A_TXLEN  = 8'h04;
	localparam logic [7:0] A_STATUS = 8'h08;
	localparam logic [7:0] A_IDS_A  = 8'h0c;
	localparam logic [7:0] A_IDS_B  = 8'h10;
	localparam logic [7:0] A_HIB    = 8'h14;
	localparam logic [2:0] A_TXBUF_PAGE = 3'h1;
	localparam logic [2:0] A_RXBUF_PAGE = 3'h2;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int CTRL_START_BIT = 8;
	localparam int CTRL_RXCLR_BIT = 9;
	localparam int ST_TX_BUSY     = 0;
	localparam int ST_TX_ERR      = 1;
	localparam int ST_RX_DONE     = 2;
	localparam int ST_LEN_ERR     = 3;
	localparam int ST_CODE_ERR    = 4;
	localparam int ST_KIND_LSB    = 5;
	localparam int ST_RXLEN_LSB   = 8;
	localparam int ST_HIB_NOW     = 16;
	localparam int ST_WAKE_NEXT   = 17;
	// Element identifiers: arbitrary defaults, software reprograms them
	localparam logic [31:0] IDS_A_RST = 32'h13121110;
	localparam logic [7:0]  IDS_B_RST = 8'h14;

	// ----------------------------------------------------------------
	// Element structure
	// ----------------------------------------------------------------
	localparam int         BUF_OCTETS  = 32;
	localparam logic [7:0] AVAIL_MAX   = 8'h20;
	localparam logic [7:0] MODE_LEN    = 8'h02;
	localparam logic [7:0] VID_LEN     = 8'h03;
	localparam logic [7:0] VTYPE_LEN   = 8'h06;
	localparam logic [7:0] DI_VID      = 8'h00;
	localparam logic [7:0] DI_VTYPE    = 8'h01;
	localparam logic [7:0] DI_NAME     = 8'h02;
	localparam logic [3:0] PWR_RES_LO  = 4'h3;
	localparam logic [3:0] PWR_RES_HI  = 4'hd;
	localparam logic [3:0] RATE_RES_LO = 4'he;

	typedef enum logic [2:0] {
		K_AVAIL  = 3'h0,
		K_ANCHOR = 3'h1,
		K_MODE   = 3'h2,
		K_IDENT  = 3'h3,
		K_LINK   = 3'h4,
		K_NONE   = 3'h7
	} iec_kind_e;

	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_ID   = 2'b01,
		TX_LEN  = 2'b11,
		TX_DATA = 2'b10
	} iec_tx_e;

	typedef enum logic [1:0] {
		RX_ID   = 2'b00,
		RX_LEN  = 2'b01,
		RX_DATA = 2'b11,
		RX_SKIP = 2'b10
	} iec_rx_e;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} iec_apb_req_s;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} iec_apb_rsp_s;

	typedef struct packed {
		logic       valid;
		logic       first;
		logic [7:0] data;
	} iec_oct_s;

	typedef struct packed {
		logic [BUF_OCTETS-1:0][7:0] oct;
	} iec_buf_s;

endpackage

// ===== core/iec_octet_buf.sv
// Octet buffer with word and octet write ports
`timescale 1ns/10ps
module iec_octet_buf (
	input  wire logic        sys_clk_in,
	input  wire logic        reset_in,
	input  wire logic        clear_in,
	input  wire logic        wr_word_in,
	input  wire logic [2:0]  word_idx_in,
	input  wire logic [31:0] word_in,
	input  wire logic        wr_oct_in,
	input  wire logic [4:0]  oct_idx_in,
	input  wire logic [7:0]  oct_in,
	output iec_pkg::iec_buf_s data_out
);
	import iec_pkg::*;

	iec_buf_s state;
	iec_buf_s next_state;

	always_comb begin
		next_state = state;
		for (int i = 0; i < BUF_OCTETS; i++) begin
			// Clear first so a write in the same cycle still lands
			if (clear_in) begin
				next_state.oct[i] = 8'h00;
			end
			if (wr_word_in && (word_idx_in == 3'(i / 4))) begin
				next_state.oct[i] = word_in[(i % 4) * 8 +: 8];
			end
			if (wr_oct_in && (oct_idx_in == 5'(i))) begin
				next_state.oct[i] = oct_in;
			end
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign data_out = state;
endmodule

// ===== core/iec_codec_top.sv
// Information element encoder and parser with APB register access
//
// Overview of operation
// (RULE1) Availability bitmap up to 256 bits; bit 0 is the first slot.
// (RULE2) Encoder sends availability bit one where a reservation is acceptable.
// (RULE3) Availability length 0..32; absent trailing octets parse as zero.
// (RULE4) Hibernation anchor length is three per entry: address, countdown.
// (RULE5) Wakeup countdown zero means neighbour active next superframe.
// (RULE6) Hibernation mode length is 2: countdown then duration.
// (RULE7) Hibernation countdown zero means hibernating at current superframe end.
// (RULE8) Duration octet gives superframes the device stays hibernating.
// (RULE9) Identification entries: type, length, data; total equals element length.
// (RULE10) Entry type 0 vendor id, 1 vendor type, 2 name, others reserved.
// (RULE11) Vendor identifier is three octets sent in ascending index order.
// (RULE12) Vendor type carries three octet organisation then three octet type.
// (RULE13) Name string is little-endian two-octet characters.
// (RULE14) Link feedback length is three per link entry.
// (RULE15) Link entry: rate bits 23-20, power 19-16, address 15-0.
// (RULE16) Power codes 1110,1111,0000,0001,0010 valid; others reserved.
// (RULE17) Rate codes 14 and 15 always reserved.
// (RULE18) Parser flags bad lengths and reserved codes; identifiers configurable.
`timescale 1ns/10ps
module iec_codec_top (
	input  wire logic              sys_clk_in,
	input  wire logic              reset_in,
	input  wire iec_pkg::iec_apb_req_s apb_in,
	output iec_pkg::iec_apb_rsp_s  apb_out,
	output iec_pkg::iec_oct_s      tx_out,
	input  wire logic              tx_ready_in,
	input  wire iec_pkg::iec_oct_s rx_in
);
	import iec_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		iec_apb_rsp_s rsp;
		iec_kind_e    tx_kind;
		logic [5:0]   tx_len;
		logic [31:0]  ids_a;
		logic [7:0]   id_link;
		iec_tx_e      tx_st;
		logic [5:0]   tx_pos;
		logic         tx_err;
		iec_oct_s     tx;
		iec_rx_e      rx_st;
		iec_kind_e    rx_kind;
		logic [7:0]   rx_len;
		logic [7:0]   rx_pos;
		logic [1:0]   trip;
		logic [1:0]   id_ph;
		logic [7:0]   ent_left;
		logic         rx_done;
		logic         len_err;
		logic         code_err;
	} iec_state_s;

	iec_state_s state;
	iec_state_s next_state;
	iec_buf_s   tx_buf;
	iec_buf_s   rx_buf;
	logic       txb_wr;
	logic       rxb_wr;
	logic       rxb_clr;
	logic       wr_go;
	logic [2:0] word_idx;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic iec_kind_e kind_of(input logic [7:0] id, input logic [31:0] ids_a,
			input logic [7:0] id_link);
		if (id == ids_a[7:0]) begin
			return K_AVAIL;
		end else if (id == ids_a[15:8]) begin
			return K_ANCHOR;
		end else if (id == ids_a[23:16]) begin
			return K_MODE;
		end else if (id == ids_a[31:24]) begin
			return K_IDENT;
		end else if (id == id_link) begin
			return K_LINK;
		end
		return K_NONE;
	endfunction

	function automatic logic [7:0] id_of(input iec_kind_e k, input logic [31:0] ids_a,
			input logic [7:0] id_link);
		case (k)
			K_AVAIL:  return ids_a[7:0];
			K_ANCHOR: return ids_a[15:8];
			K_MODE:   return ids_a[23:16];
			K_IDENT:  return ids_a[31:24];
			default:  return id_link;
		endcase
	endfunction

	// True when a length octet cannot belong to the element kind
	function automatic logic len_bad(input iec_kind_e k, input logic [7:0] len);
		case (k)
			K_AVAIL:  return len > AVAIL_MAX; // RULE3
			K_ANCHOR: return (len % 8'h03) != 8'h00; // RULE4
			K_MODE:   return len != MODE_LEN; // RULE6
			K_LINK:   return (len % 8'h03) != 8'h00; // RULE14
			K_IDENT:  return 1'b0;
			default:  return 1'b1;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Buffers
	// ----------------------------------------------------------------
	iec_octet_buf u_tx_buf (
		.sys_clk_in  (sys_clk_in),
		.reset_in    (reset_in),
		.clear_in    (1'b0),
		.wr_word_in  (txb_wr),
		.word_idx_in (word_idx),
		.word_in     (apb_in.pwdata),
		.wr_oct_in   (1'b0),
		.oct_idx_in  (5'h00),
		.oct_in      (8'h00),
		.data_out    (tx_buf)
	);

	// Cleared at every element start so a short bitmap reads zero above its end
	iec_octet_buf u_rx_buf (
		.sys_clk_in  (sys_clk_in),
		.reset_in    (reset_in),
		.clear_in    (rxb_clr),
		.wr_word_in  (1'b0),
		.word_idx_in (3'h0),
		.word_in     (32'h0000_0000),
		.wr_oct_in   (rxb_wr),
		.oct_idx_in  (state.rx_pos[4:0]),
		.oct_in      (rx_in.data),
		.data_out    (rx_buf)
	);

	assign word_idx = apb_in.paddr[4:2];
	assign wr_go    = apb_in.psel & apb_in.penable & apb_in.pwrite & state.rsp.pready;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [31:0] rd;
		logic        unmapped;
		logic [7:0]  d;
		logic        last;
		logic        ent_done;
		rd         = 32'h0000_0000;
		unmapped   = 1'b0;
		d          = rx_in.data;
		last       = 1'b0;
		ent_done   = 1'b0;
		next_state = state;
		txb_wr     = 1'b0;
		rxb_wr     = 1'b0;
		rxb_clr    = 1'b0;

		// Zero-wait slave: answer is prepared in setup, given in access
		next_state.rsp.pready  = 1'b0;
		next_state.rsp.pslverr = 1'b0;
		if (apb_in.psel && !apb_in.penable) begin
			case (apb_in.paddr)
				A_CTRL:   rd = {29'h0, state.tx_kind};
				A_TXLEN:  rd = {26'h0, state.tx_len};
				A_STATUS: begin
					rd[ST_TX_BUSY] = state.tx_st != TX_IDLE;
					rd[ST_TX_ERR] = state.tx_err;
					rd[ST_RX_DONE] = state.rx_done;
					rd[ST_LEN_ERR] = state.len_err;
					rd[ST_CODE_ERR] = state.code_err;
					rd[ST_KIND_LSB +: 3] = state.rx_kind;
					rd[ST_RXLEN_LSB +: 8] = state.rx_len;
					rd[ST_HIB_NOW] = (state.rx_kind == K_MODE) &&
						(rx_buf.oct[0] == 8'h00); // RULE7
					rd[ST_WAKE_NEXT] = (state.rx_kind == K_ANCHOR) &&
						(state.rx_len != 8'h00) && (rx_buf.oct[2] == 8'h00); // RULE5
				end
				A_IDS_A:  rd = state.ids_a;
				A_IDS_B:  rd = {24'h0, state.id_link};
				A_HIB:    rd = {16'h0, rx_buf.oct[1], rx_buf.oct[0]}; // RULE6 RULE8
				default: begin
					if (apb_in.paddr[7:5] == A_TXBUF_PAGE && apb_in.paddr[1:0] == 2'b00) begin
						rd = tx_buf.oct[word_idx * 4 +: 4];
					end else if (apb_in.paddr[7:5] == A_RXBUF_PAGE &&
							apb_in.paddr[1:0] == 2'b00) begin
						rd = rx_buf.oct[word_idx * 4 +: 4]; // RULE1
					end else begin
						unmapped = 1'b1;
					end
				end
			endcase
			next_state.rsp.prdata  = rd;
			next_state.rsp.pready  = 1'b1;
			next_state.rsp.pslverr = unmapped;
		end

		if (wr_go) begin
			case (apb_in.paddr)
				A_CTRL: begin
					next_state.tx_kind = iec_kind_e'(apb_in.pwdata[2:0]);
					if (apb_in.pwdata[CTRL_RXCLR_BIT]) begin
						next_state.rx_done  = 1'b0;
						next_state.len_err  = 1'b0;
						next_state.code_err = 1'b0;
					end
					if (apb_in.pwdata[CTRL_START_BIT] && state.tx_st == TX_IDLE) begin
						// Refuse a length the element cannot carry
						if (len_bad(iec_kind_e'(apb_in.pwdata[2:0]), {2'b00, state.tx_len}) ||
								state.tx_len > 6'(BUF_OCTETS)) begin
							next_state.tx_err = 1'b1; // RULE18
						end else begin
							next_state.tx_err = 1'b0;
							next_state.tx_st  = TX_ID;
							next_state.tx = {1'b1, 1'b1, id_of(iec_kind_e'(apb_in.pwdata[2:0]),
								state.ids_a, state.id_link)}; // RULE18
						end
					end
				end
				A_TXLEN:  next_state.tx_len = apb_in.pwdata[5:0];
				A_IDS_A:  next_state.ids_a = apb_in.pwdata;
				A_IDS_B:  next_state.id_link = apb_in.pwdata[7:0];
				default:  txb_wr = (apb_in.paddr[7:5] == A_TXBUF_PAGE) &&
					(apb_in.paddr[1:0] == 2'b00); // RULE2
			endcase
		end

		// ------------------------------------------------------------
		// Encoder: identifier, length, then buffer octets from index 0
		// ------------------------------------------------------------
		if (state.tx.valid && tx_ready_in) begin
			next_state.tx.first = 1'b0;
			case (state.tx_st)
				TX_ID: begin
					next_state.tx_st   = TX_LEN;
					next_state.tx.data = {2'b00, state.tx_len};
				end
				TX_LEN, TX_DATA: begin
					if (state.tx_pos == state.tx_len) begin
						next_state.tx_st    = TX_IDLE;
						next_state.tx.valid = 1'b0;
						next_state.tx_pos   = 6'h00;
					end else begin
						next_state.tx_st   = TX_DATA;
						next_state.tx.data = tx_buf.oct[state.tx_pos[4:0]]; // RULE11
						next_state.tx_pos  = state.tx_pos + 6'h01;
					end
				end
				default: next_state.tx_st = TX_IDLE;
			endcase
		end

		// ------------------------------------------------------------
		// Parser; its flag sets follow the software clear so set wins
		// ------------------------------------------------------------
		if (rx_in.valid && rx_in.first) begin
			rxb_clr             = 1'b1; // RULE3
			next_state.rx_kind  = kind_of(d, state.ids_a, state.id_link); // RULE18
			next_state.rx_st    = (kind_of(d, state.ids_a, state.id_link) == K_NONE) ?
				RX_SKIP : RX_LEN;
			next_state.rx_done  = 1'b0;
			next_state.len_err  = 1'b0;
			next_state.code_err = 1'b0;
			next_state.rx_len   = 8'h00;
		end else if (rx_in.valid) begin
			case (state.rx_st)
				RX_LEN: begin
					next_state.rx_len   = d;
					next_state.rx_pos   = 8'h00;
					next_state.trip     = 2'b00;
					next_state.id_ph    = 2'b00;
					next_state.len_err  = len_bad(state.rx_kind, d); // RULE18
					next_state.rx_st    = (d == 8'h00) ? RX_ID : RX_DATA;
					next_state.rx_done  = (d == 8'h00);
				end
				RX_DATA: begin
					last              = state.rx_pos == state.rx_len - 8'h01;
					rxb_wr            = state.rx_pos < 8'(BUF_OCTETS);
					next_state.rx_pos = state.rx_pos + 8'h01;
					next_state.trip   = (state.trip == 2'b10) ? 2'b00 : state.trip + 2'b01;
					// Octet 2 of a link entry holds bits 23-16
					if (state.rx_kind == K_LINK && state.trip == 2'b10) begin // RULE15
						if (d[3:0] >= PWR_RES_LO && d[3:0] <= PWR_RES_HI) begin
							next_state.code_err = 1'b1; // RULE16
						end
						if (d[7:4] >= RATE_RES_LO) begin
							next_state.code_err = 1'b1; // RULE17
						end
					end
					if (state.rx_kind == K_IDENT) begin
						case (state.id_ph)
							2'b00: begin
								next_state.id_ph = 2'b01;
								if (d > DI_NAME) begin
									next_state.code_err = 1'b1; // RULE10
								end
							end
							2'b01: begin
								next_state.ent_left = d;
								next_state.id_ph    = (d == 8'h00) ? 2'b00 : 2'b10;
								ent_done            = d == 8'h00;
								// Type octet is one behind the current data octet
								if ((rx_buf.oct[state.rx_pos[4:0] - 5'h01] == DI_VID &&
										d != VID_LEN) || // RULE11
										(rx_buf.oct[state.rx_pos[4:0] - 5'h01] == DI_VTYPE &&
										d != VTYPE_LEN) || // RULE12
										(rx_buf.oct[state.rx_pos[4:0] - 5'h01] == DI_NAME &&
										d[0])) begin // RULE13
									next_state.len_err = 1'b1;
								end
							end
							default: begin
								next_state.ent_left = state.ent_left - 8'h01;
								ent_done            = state.ent_left == 8'h01;
								if (ent_done) begin
									next_state.id_ph = 2'b00;
								end
							end
						endcase
						// Element must end exactly on an entry boundary
						if (last && !ent_done) begin
							next_state.len_err = 1'b1; // RULE9
						end
					end
					if (last) begin
						next_state.rx_st   = RX_ID;
						next_state.rx_done = 1'b1;
					end
				end
				default: next_state.rx_st = state.rx_st;
			endcase
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			state          <= '0;
			state.tx_kind  <= K_AVAIL;
			state.ids_a    <= IDS_A_RST;
			state.id_link  <= IDS_B_RST;
			state.tx_st    <= TX_IDLE;
			state.rx_st    <= RX_ID;
			state.rx_kind  <= K_NONE;
		end else begin
			state <= next_state;
		end
	end

	assign apb_out = state.rsp;
	assign tx_out  = state.tx;
endmodule

// ===== bench/iec_codec_checker.sv
// Port checker for the information element codec
`timescale 1ns/10ps
module iec_codec_checker (
	input wire logic                  sys_clk_in,
	input wire logic                  reset_in,
	input wire iec_pkg::iec_apb_req_s apb_in,
	input wire iec_pkg::iec_apb_rsp_s apb_out,
	input wire iec_pkg::iec_oct_s     tx_out,
	input wire logic                  tx_ready_in,
	input wire iec_pkg::iec_oct_s     rx_in
);
	import iec_pkg::*;
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (reset_in);

	// ----------------------------------------------------------------
	// Sequences and helpers
	// ----------------------------------------------------------------
	logic start_seen;

	sequence s_setup;
		apb_in.psel && !apb_in.penable;
	endsequence

	sequence s_id_taken;
		tx_out.valid && tx_out.first && tx_ready_in;
	endsequence

	// Registered so the cause can be named in the cycle of the effect, one cycle after the cause
	always_ff @(posedge sys_clk_in) begin
		if (reset_in)
			start_seen <= 1'b0;
		else
			start_seen <= apb_in.psel && apb_in.penable && apb_out.pready
				&& apb_in.pwrite && apb_in.paddr == A_CTRL && apb_in.pwdata[CTRL_START_BIT];
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_pready_answer: assert property (s_setup |=> apb_out.pready)
		else $error("no ready in access cycle");
	a_pready_pulse: assert property (apb_out.pready |=> !apb_out.pready)
		else $error("ready held too long");
	a_err_reads_zero: assert property (apb_out.pready && apb_out.pslverr |-> apb_out.prdata == 32'h0)
		else $error("error read data not zero");
	a_misalign_err: assert property (apb_in.psel && apb_in.penable && apb_out.pready
		&& apb_in.paddr[1:0] != 2'h0 |-> apb_out.pslverr)
		else $error("unaligned access not refused");
	a_tx_hold: assert property (tx_out.valid && !tx_ready_in |=> tx_out.valid
		&& $stable(tx_out.data) && $stable(tx_out.first))
		else $error("octet changed while stalled");
	a_len_follows: assert property (s_id_taken |=> tx_out.valid && !tx_out.first
		&& tx_out.data <= AVAIL_MAX)
		else $error("length octet missing or too big");
	a_start_cause: assert property ($rose(tx_out.valid) |-> start_seen)
		else $error("element sent without start");
	a_reset_quiet: assert property (@(posedge sys_clk_in) disable iff (1'b0)
		reset_in |=> !tx_out.valid && !apb_out.pready)
		else $error("outputs active in reset");
endmodule

bind iec_codec_top iec_codec_checker i_iec_codec_checker (
	.sys_clk_in (sys_clk_in),
	.reset_in   (reset_in),
	.apb_in     (apb_in),
	.apb_out    (apb_out),
	.tx_out     (tx_out),
	.tx_ready_in(tx_ready_in),
	.rx_in      (rx_in)
);

// ===== bench/iec_phy_model.sv
// Far side model: stalling octet sink and octet source
`timescale 1ns/10ps
module iec_phy_model (
	input  wire logic              sys_clk_in,
	input  wire iec_pkg::iec_oct_s tx_in,
	output iec_pkg::iec_oct_s      rx_out,
	output logic                   tx_ready_out
);
	import iec_pkg::*;
	logic [7:0] got[$];
	logic [1:0] cnt;

	initial begin
		tx_ready_out = 1'b0;
		rx_out = '0;
		cnt = 2'h0;
	end

	// Stalls one cycle in four so held octets are exercised
	always @(posedge sys_clk_in) begin
		if (tx_in.valid && tx_ready_out)
			got.push_back(tx_in.data);
		cnt <= cnt + 2'h1;
		tx_ready_out <= cnt != 2'h3;
	end

	task automatic send(input logic [7:0] q[$]);
		foreach (q[i]) begin
			@(posedge sys_clk_in);
			rx_out <= '{1'b1, i == 0, q[i]};
		end
		@(posedge sys_clk_in);
		// Idle line never repeats the last octet
		rx_out <= '{1'b0, 1'b0, ~q[q.size()-1]};
	endtask
endmodule

// ===== bench/iec_codec_top_test.sv
// Self-checking bench for the information element codec
`timescale 1ns/10ps
module iec_codec_top_test;
	import iec_pkg::*;
	localparam logic [31:0] M = 32'h3fffc;
	logic         sys_clk_in;
	logic         reset_in;
	logic         tx_ready_in;
	iec_apb_req_s apb_in;
	iec_apb_rsp_s apb_out;
	iec_oct_s     tx_out;
	iec_oct_s     rx_in;
	logic [31:0]  rd;
	logic         err;
	int           miscompares = 0;
	int           num_checks = 0;
	int           cycles = 0;

	iec_codec_top i_iec_codec_top (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
		.apb_in(apb_in), .apb_out(apb_out), .tx_out(tx_out),
		.tx_ready_in(tx_ready_in), .rx_in(rx_in));
	iec_phy_model i_iec_phy_model (.sys_clk_in(sys_clk_in), .tx_in(tx_out),
		.rx_out(rx_in), .tx_ready_out(tx_ready_in));

	// ----------------------------------------------------------------
	// Clock, timeout, common tasks
	// ----------------------------------------------------------------
	initial begin
		sys_clk_in = 1'b0;
		forever #5 sys_clk_in = ~sys_clk_in;
	end

	always @(posedge sys_clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			complete_run();
		end
	end

	task automatic complete_run();
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk_in);
		apb_in <= '{1'b1, 1'b0, w, a, d};
		@(posedge sys_clk_in);
		apb_in.penable <= 1'b1;
		@(posedge sys_clk_in iff apb_out.pready === 1'b1);
		rd = apb_out.prdata;
		err = apb_out.pslverr;
		apb_in <= '0;
	endtask

	function automatic logic [31:0] word_of(input logic [7:0] q[$], input int k);
		logic [31:0] w = '0;
		for (int b = 0; b < 4; b++)
			if (4 * k + b < q.size())
				w[8*b +: 8] = q[4*k+b];
		return w;
	endfunction

	function automatic logic [31:0] st(input logic [2:0] k, input logic [7:0] n,
		input logic [1:0] e, input logic [1:0] h);
		return {14'h0, h, n, k, e, 1'b1, 2'h0};
	endfunction

	task automatic tx_go(input logic [2:0] kind, input logic [7:0] id, input logic [7:0] q[$]);
		for (int k = 0; k < 8; k++)
			apb(1'b1, 8'h20 + 8'(4 * k), word_of(q, k));
		i_iec_phy_model.got.delete();
		apb(1'b1, A_TXLEN, 32'(q.size()));
		apb(1'b1, A_CTRL, 32'h100 | 32'(kind));
		// Polled per edge; a queue size is not a safe event expression
		while (i_iec_phy_model.got.size() < q.size() + 2)
			@(posedge sys_clk_in);
		check("tx id", 32'(i_iec_phy_model.got[0]), 32'(id));
		check("tx length", 32'(i_iec_phy_model.got[1]), 32'(q.size()));
		foreach (q[i])
			check("tx body", 32'(i_iec_phy_model.got[i+2]), 32'(q[i]));
	endtask

	task automatic rx_go(input logic [7:0] q[$], input logic [31:0] mask, input logic [31:0] exp);
		i_iec_phy_model.send(q);
		apb(1'b0, A_STATUS, 32'h0);
		check("rx status", rd & mask, exp);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_regs();
		apb(1'b0, A_IDS_A, 32'h0);
		check("ids a", rd, IDS_A_RST);
		apb(1'b1, A_IDS_B, 32'h55);
		apb(1'b0, A_IDS_B, 32'h0);
		check("ids b", rd & 32'hff, 32'h55);
		apb(1'b1, A_IDS_B, 32'(IDS_B_RST));
		apb(1'b0, 8'h60, 32'h0);
		check("unmapped", {31'h0, err}, 32'h1);
		apb(1'b0, 8'h22, 32'h0);
		check("unaligned", {31'h0, err}, 32'h1);
	endtask

	task automatic t_tx();
		logic [7:0] q[$];
		for (int i = 0; i < 32; i++)
			q.push_back(8'(i * 37));
		tx_go(K_AVAIL, 8'h10, q);
		tx_go(K_MODE, 8'h12, '{8'h00, 8'h05});
		tx_go(K_ANCHOR, 8'h11, '{8'h34, 8'h12, 8'h00});
		tx_go(K_IDENT, 8'h13, '{8'h00, 8'h03, 8'haa, 8'hbb, 8'hcc});
		tx_go(K_LINK, 8'h14, '{8'h34, 8'h12, 8'h1e, 8'h78, 8'h56, 8'h72});
		i_iec_phy_model.got.delete();
		apb(1'b1, A_TXLEN, 32'h3);
		apb(1'b1, A_CTRL, 32'h100 | 32'(K_MODE));
		repeat (10) @(posedge sys_clk_in);
		check("refused sent", 32'(i_iec_phy_model.got.size()), 32'h0);
		apb(1'b0, A_STATUS, 32'h0);
		check("refused flag", rd & 32'h2, 32'h2);
	endtask

	task automatic t_rx();
		logic [7:0] code[10] = '{8'he0, 8'hf0, 8'h0e, 8'h0f, 8'h00, 8'h01, 8'h02, 8'h03,
			8'h0d, 8'hd2};
		logic [1:0] bad[10] = '{2, 2, 0, 0, 0, 0, 0, 2, 2, 0};
		rx_go('{8'h10, 8'h03, 8'hff, 8'h01, 8'h80}, M, st(K_AVAIL, 3, 0, 0));
		apb(1'b0, 8'h40, 32'h0);
		check("avail word0", rd, 32'h008001ff);
		apb(1'b0, 8'h44, 32'h0);
		check("avail word1", rd, 32'h0);
		rx_go('{8'h12, 8'h02, 8'h00, 8'h07}, M, st(K_MODE, 2, 0, 1));
		apb(1'b0, A_HIB, 32'h0);
		check("hib", rd & 32'hffff, 32'h0700);
		rx_go('{8'h12, 8'h03, 8'h01, 8'h02, 8'h03}, M, st(K_MODE, 3, 1, 0));
		rx_go('{8'h11, 8'h03, 8'h34, 8'h12, 8'h00}, M, st(K_ANCHOR, 3, 0, 2));
		rx_go('{8'h11, 8'h04, 8'h34, 8'h12, 8'h05, 8'h00}, M, st(K_ANCHOR, 4, 1, 0));
		rx_go('{8'h13, 8'h05, 8'h00, 8'h03, 8'haa, 8'hbb, 8'hcc}, M, st(K_IDENT, 5, 0, 0));
		rx_go('{8'h13, 8'h03, 8'h03, 8'h01, 8'h00}, M, st(K_IDENT, 3, 2, 0));
		rx_go('{8'h13, 8'h04, 8'h00, 8'h02, 8'haa, 8'hbb}, M, st(K_IDENT, 4, 1, 0));
		rx_go('{8'h13, 8'h03, 8'h00, 8'h03, 8'haa}, M, st(K_IDENT, 3, 1, 0));
		rx_go('{8'h13, 8'h08, 8'h01, 8'h06, 8'h1, 8'h2, 8'h3, 8'h4, 8'h5, 8'h6}, M,
			st(K_IDENT, 8, 0, 0));
		rx_go('{8'h13, 8'h05, 8'h02, 8'h03, 8'h41, 8'h00, 8'h42}, M, st(K_IDENT, 5, 1, 0));
		rx_go('{8'h13, 8'h06, 8'h02, 8'h04, 8'h41, 8'h00, 8'h42, 8'h00}, M,
			st(K_IDENT, 6, 0, 0));
		for (int i = 0; i < 10; i++)
			rx_go('{8'h14, 8'h03, 8'h34, 8'h12, code[i]}, M, st(K_LINK, 3, bad[i], 0));
		rx_go('{8'h14, 8'h04, 8'h34, 8'h12, 8'h00, 8'h00}, M, st(K_LINK, 4, 1, 0));
		apb(1'b1, A_CTRL, 32'h200);
		apb(1'b0, A_STATUS, 32'h0);
		check("rx flags clear", rd & 32'h1c, 32'h0);
		rx_go('{8'h77, 8'h01, 8'h00}, 32'he0, 32'he0);
	endtask

	initial begin
		apb_in = '0;
		reset_in = 1'b1;
		repeat (12) @(posedge sys_clk_in);
		reset_in <= 1'b0;
		t_regs();
		t_tx();
		t_rx();
		complete_run();
	end
endmodule
